/* slp_aux_clk_gen.sv */
`timescale 1ns/1ns
`include "slp_defines.svh"

module slp_aux_clk_gen #(
    parameter int MCLK_KHZ = `SLP_MCLK_KHZ,
    parameter int AUX_KHZ = `SLP_AUX_KHZ
) (
    input wire logic mclk,
    input wire logic rst_n,
    output logic clk_o
);

    // ************************************************************
    // phase accumulator, toggles at twice the aux rate on average
    // ************************************************************
    localparam int AW = $clog2(MCLK_KHZ + 2 * AUX_KHZ + 1);
    localparam logic [AW-1:0] STEP = AW'(2 * AUX_KHZ);
    localparam logic [AW-1:0] WRAP = AW'(MCLK_KHZ);

    logic [AW-1:0] acc_ff;
    logic [AW-1:0] nxt_acc;
    logic [AW-1:0] sum;
    logic wrap_hit;
    logic [3:0] gap_ff;

    assign sum = acc_ff + STEP;
    assign wrap_hit = (sum >= WRAP);
    assign nxt_acc = wrap_hit ? sum - WRAP : sum;

    // accumulator and output toggle
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_ff <= '0;
            clk_o <= 1'b0;
        end
        else
        begin
            acc_ff <= nxt_acc;
            clk_o <= clk_o ^ wrap_hit;
        end
    end

    // cycles since the last toggle, for checking only
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            gap_ff <= 4'h0;
        else
            gap_ff <= wrap_hit ? 4'h0 : gap_ff + 4'h1;
    end

    chk_aux_half_period:
    assert property (@(posedge mclk) disable iff (!rst_n)
        gap_ff <= 4'h6)
    else $error("aux clock half period too long");

endmodule // slp_aux_clk_gen

/* slp_board.sv */
`timescale 1ns/1ns

// ****************************************
// board straps and pin pull resistors
// ****************************************
module slp_board (
    input wire logic [3:0] strap_hi,
    input wire logic [3:0] pin_o,
    input wire logic [3:0] pin_oe_n,
    output logic [3:0] pin_i,
    output logic [3:0] op_straps
);
    // a released pin sits at its strap resistor level
    assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & strap_hi);
    // mode straps held at the normal setting
    assign op_straps = 4'h3;
endmodule // slp_board

/* slp_defines.svh */
`ifndef SLP_DEFINES_SVH
`define SLP_DEFINES_SVH

// ************************************************************
// register word indexes, byte address is four times the index
// ************************************************************
`define SLP_IDX_GP_CTRL 6'h00
`define SLP_IDX_GP_DATA 6'h01
`define SLP_IDX_STRAP 6'h02
`define SLP_IDX_PHY 6'h03
`define SLP_IDX_IRQ_STAT 6'h04
`define SLP_IDX_IRQ_MASK 6'h05

// ************************************************************
// field layout and reset values
// ************************************************************
`define SLP_GP_W 7
`define SLP_GP_DIR_FORCED 7'h71
`define SLP_GP_DIR_RST 7'h71
`define SLP_GP_OUT_RST 7'h01
`define SLP_IRQ_W 3
`define SLP_IRQ_WAKE 0
`define SLP_IRQ_LINK 1
`define SLP_IRQ_MODE 2
`define SLP_OP_NORMAL 4'h3
`define SLP_LED_SPEED 0
`define SLP_LED_DUPLEX 1
`define SLP_LED_LINK 2

// ************************************************************
// timing
// ************************************************************
`define SLP_CLK_PERIOD_NS 4
`define SLP_READY_TIME_NS 5000
`define SLP_READY_CYC ((`SLP_READY_TIME_NS + `SLP_CLK_PERIOD_NS - 1) / `SLP_CLK_PERIOD_NS)
`define SLP_MCLK_KHZ 250000
`define SLP_AUX_KHZ 20000

`endif

/* slp_misc_pins.sv */
`timescale 1ns/1ns
`include "slp_defines.svh"

module slp_misc_pins #(
    parameter int READY_CYC = `SLP_READY_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire slp_pkg::slp_phy_s phy_i,
    input wire logic [3:0] operation_mode_straps,
    input wire logic clock_source_select,
    input wire logic eeprom_data_out_d,
    input wire logic eeprom_select_d,
    input wire logic wake_i,
    output logic wake_o,
    output logic wake_oe_n,
    input wire logic eeprom_data_out_i,
    output logic eeprom_data_out_o,
    output logic eeprom_data_out_oe_n,
    input wire logic eeprom_select_i,
    output logic eeprom_select_o,
    output logic eeprom_select_oe_n,
    input wire logic link_status_i,
    output logic link_status_o,
    output logic link_status_oe_n,
    output logic aux_clock_out_o,
    output logic aux_clock_out_oe_n,
    output logic sys_clk_from_aux,
    input wire logic [6:0] general_pins_i,
    output logic [6:0] general_pins_o,
    output logic [6:0] general_pins_oe_n,
    output logic [2:0] led_o,
    output logic [2:0] led_oe_n,
    output slp_pkg::slp_width_e mem_width,
    output logic led_mode,
    output logic rev_mii,
    output logic ready_o,
    output logic irq_o
);

    // ************************************************************
    // declarations
    // ************************************************************
    localparam int CW = $clog2(READY_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(READY_CYC - 1);

    slp_pkg::slp_state_e state_ff, nxt_state;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [3:0] op_mode_ff;
    logic [6:0] gp_dir_ff, gp_out_ff, nxt_gp_dir, nxt_gp_out;
    logic [2:0] irq_stat_ff, irq_mask_ff, nxt_irq_stat, irq_ev, led_on;
    logic link_q_ff, speed_q_ff, duplex_q_ff, aux_clk, capture;
    logic wb_req, wb_wr, wb_rd;
    logic [5:0] wb_idx;
    logic hit_gp_ctrl, hit_gp_data, hit_strap, hit_phy, hit_stat, hit_mask;
    logic [31:0] rd_mux, strap_word, phy_word;

    // ************************************************************
    // aux clock generator
    // ************************************************************
    slp_aux_clk_gen u_aux_clk (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_o(aux_clk)
    );

    // ************************************************************
    // reset sequencing and strap capture
    // ************************************************************
    // first cycle after release captures, then wait for ready time
    assign capture = (state_ff == slp_pkg::slp_st_capture);
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            slp_pkg::slp_st_capture:
            begin
                nxt_state = slp_pkg::slp_st_wait;
                nxt_cnt = '0;
            end
            slp_pkg::slp_st_wait:
            begin
                nxt_cnt = cnt_ff + CW'(1);
                if (cnt_ff == CNT_LAST)
                    nxt_state = slp_pkg::slp_st_ready;
            end
            slp_pkg::slp_st_ready:
                nxt_state = slp_pkg::slp_st_ready;
            default:
                nxt_state = slp_pkg::slp_st_capture;
        endcase
    end

    // state, counter and ready flag
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= slp_pkg::slp_st_capture;
            cnt_ff <= '0;
            ready_o <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            ready_o <= (nxt_state == slp_pkg::slp_st_ready);
        end
    end

    // strap latches, loaded once while the pins still float
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_width <= slp_pkg::slp_w16;
            led_mode <= 1'b0;
            rev_mii <= 1'b0;
            op_mode_ff <= 4'h0;
        end
        else if (capture)
        begin
            mem_width <= slp_pkg::slp_decode_width(wake_i,
                                                   eeprom_data_out_i);
            led_mode <= eeprom_select_i;
            rev_mii <= link_status_i;
            op_mode_ff <= operation_mode_straps;
        end
    end

    // ************************************************************
    // strap pins, aux clock pin and clock source
    // ************************************************************
    // straps float in reset and capture, aux pin floats as clock input
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_oe_n <= 1'b1;
            eeprom_data_out_oe_n <= 1'b1;
            eeprom_select_oe_n <= 1'b1;
            link_status_oe_n <= 1'b1;
            wake_o <= 1'b0;
            eeprom_data_out_o <= 1'b0;
            eeprom_select_o <= 1'b0;
            link_status_o <= 1'b0;
            aux_clock_out_o <= 1'b0;
            aux_clock_out_oe_n <= 1'b1;
            sys_clk_from_aux <= 1'b0;
        end
        else
        begin
            wake_oe_n <= capture;
            eeprom_data_out_oe_n <= capture;
            eeprom_select_oe_n <= capture;
            link_status_oe_n <= capture;
            wake_o <= nxt_irq_stat[`SLP_IRQ_WAKE];
            eeprom_data_out_o <= eeprom_data_out_d;
            eeprom_select_o <= eeprom_select_d;
            link_status_o <= phy_i.link;
            aux_clock_out_o <= aux_clk;
            aux_clock_out_oe_n <= clock_source_select;
            sys_clk_from_aux <= clock_source_select;
        end
    end

    // ************************************************************
    // LEDs, open drain, low when lit
    // ************************************************************
    assign led_on[`SLP_LED_SPEED] = phy_i.speed100;
    assign led_on[`SLP_LED_DUPLEX] = led_mode ? phy_i.full_duplex
                                              : !phy_i.speed100;
    assign led_on[`SLP_LED_LINK] = led_mode ? (phy_i.link & !phy_i.crs)
                                            : phy_i.crs;

    // float when unlit, value pin stays low
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            led_oe_n <= 3'h7;
            led_o <= 3'h0;
        end
        else
        begin
            led_oe_n <= ~led_on;
            led_o <= 3'h0;
        end
    end

    // ************************************************************
    // register bus decode
    // ************************************************************
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
    assign wb_rd = wb_req & ~wb_we_i;
    assign wb_idx = wb_adr_i[7:2];
    assign hit_gp_ctrl = (wb_idx == `SLP_IDX_GP_CTRL);
    assign hit_gp_data = (wb_idx == `SLP_IDX_GP_DATA);
    assign hit_strap = (wb_idx == `SLP_IDX_STRAP);
    assign hit_phy = (wb_idx == `SLP_IDX_PHY);
    assign hit_stat = (wb_idx == `SLP_IDX_IRQ_STAT);
    assign hit_mask = (wb_idx == `SLP_IDX_IRQ_MASK);

    // read words of status registers
    assign strap_word = {22'h0, sys_clk_from_aux,
                         (op_mode_ff == `SLP_OP_NORMAL), op_mode_ff,
                         rev_mii, led_mode, mem_width};
    assign phy_word = {27'h0, ready_o, phy_i.crs, phy_i.full_duplex,
                       phy_i.speed100, phy_i.link};

    // read mux, unmapped words read zero
    assign rd_mux = hit_gp_ctrl ? {25'h0, gp_dir_ff} :
                    hit_gp_data ? {25'h0, general_pins_i} :
                    hit_strap ? strap_word :
                    hit_phy ? phy_word :
                    hit_stat ? {29'h0, irq_stat_ff} :
                    hit_mask ? {29'h0, irq_mask_ff} : 32'h0;

    // one wait-free answer per request
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_rd ? rd_mux : 32'h0;
        end
    end

    // ************************************************************
    // general pins
    // ************************************************************
    // pins 0 and 4-6 stay outputs whatever is written
    assign nxt_gp_dir = (wb_wr & hit_gp_ctrl)
                        ? (wb_dat_i[6:0] | `SLP_GP_DIR_FORCED)
                        : gp_dir_ff;
    assign nxt_gp_out = (wb_wr & hit_gp_data) ? wb_dat_i[6:0] : gp_out_ff;

    // control and data registers, pin drive
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gp_dir_ff <= `SLP_GP_DIR_RST;
            gp_out_ff <= `SLP_GP_OUT_RST;
            general_pins_oe_n <= ~`SLP_GP_DIR_RST;
            general_pins_o <= `SLP_GP_OUT_RST;
        end
        else
        begin
            gp_dir_ff <= nxt_gp_dir;
            gp_out_ff <= nxt_gp_out;
            general_pins_oe_n <= ~nxt_gp_dir;
            general_pins_o <= nxt_gp_out;
        end
    end

    // ************************************************************
    // interrupts
    // ************************************************************
    assign irq_ev[`SLP_IRQ_WAKE] = phy_i.wake_event;
    assign irq_ev[`SLP_IRQ_LINK] = phy_i.link ^ link_q_ff;
    assign irq_ev[`SLP_IRQ_MODE] = (phy_i.speed100 ^ speed_q_ff)
                                 | (phy_i.full_duplex ^ duplex_q_ff);

    // read clears, a new event in the same cycle wins
    assign nxt_irq_stat = (irq_stat_ff & ~{3{wb_rd & hit_stat}}) | irq_ev;

    // sticky status, mask and interrupt level
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_stat_ff <= 3'h0;
            irq_mask_ff <= 3'h0;
            irq_o <= 1'b0;
            link_q_ff <= 1'b0;
            speed_q_ff <= 1'b0;
            duplex_q_ff <= 1'b0;
        end
        else
        begin
            irq_stat_ff <= nxt_irq_stat;
            if (wb_wr & hit_mask)
                irq_mask_ff <= wb_dat_i[2:0];
            irq_o <= |(nxt_irq_stat & irq_mask_ff);
            link_q_ff <= phy_i.link;
            speed_q_ff <= phy_i.speed100;
            duplex_q_ff <= phy_i.full_duplex;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    chk_width_strap_latch:
    assert property (capture |=> mem_width ==
        slp_pkg::slp_decode_width($past(wake_i), $past(eeprom_data_out_i)))
    else $error("memory width not taken from straps");
    chk_led_mode_latch:
    assert property (capture |=> led_mode == $past(eeprom_select_i))
    else $error("LED mode not taken from strap");
    chk_speed_led_drive:
    assert property (!capture |->
        led_oe_n[`SLP_LED_SPEED] == !$past(phy_i.speed100))
    else $error("speed LED wrong");
    chk_duplex_led_drive:
    assert property (!capture |-> led_oe_n[`SLP_LED_DUPLEX] ==
        !($past(led_mode) ? $past(phy_i.full_duplex)
                          : !$past(phy_i.speed100)))
    else $error("duplex LED wrong");
    chk_link_led_mode0:
    assert property (!capture && !led_mode && !phy_i.crs
        |=> led_oe_n[`SLP_LED_LINK])
    else $error("link LED lit without carrier");
    chk_clock_source_pin:
    assert property (clock_source_select |=>
        aux_clock_out_oe_n && sys_clk_from_aux)
    else $error("aux pin driven while used as clock");
    chk_gp_forced_out:
    assert property ((general_pins_oe_n & `SLP_GP_DIR_FORCED) == 7'h00)
    else $error("forced general pin not an output");
    chk_gp0_reset_high:
    assert property (capture |-> general_pins_o[0] && gp_out_ff[0])
    else $error("general pin 0 not high after reset");
    chk_link_status_out:
    assert property (!capture ##1 phy_i.link |=> link_status_o)
    else $error("link status pin not high with link");
    chk_rev_mii_latch:
    assert property (capture |=> rev_mii == $past(link_status_i)
        ##1 $stable(rev_mii)[*3])
    else $error("reversed MII strap not held");
    chk_wake_pin_event:
    assert property (phy_i.wake_event |=> wake_o && irq_stat_ff[0])
    else $error("wake pin not raised on event");
    // ready stays low for at least five edges from capture
    chk_ready_delay:
    assert property (capture |-> !ready_o [*5])
    else $error("ready too early");
    chk_ready_at_count:
    assert property (state_ff == slp_pkg::slp_st_wait &&
        cnt_ff == CNT_LAST |=> ready_o && !$past(ready_o))
    else $error("ready not raised at ready count");
    chk_strap_float:
    assert property (capture |-> wake_oe_n && eeprom_data_out_oe_n &&
        eeprom_select_oe_n && link_status_oe_n)
    else $error("strap pin driven before capture");

endmodule // slp_misc_pins

/* slp_pkg.sv */
package slp_pkg;

    // memory access width picked by the straps
    typedef enum logic [1:0] {
        slp_w16 = 2'b00,
        slp_w32 = 2'b01,
        slp_w8 = 2'b10,
        slp_wres = 2'b11
    } slp_width_e;

    // strap capture, ready wait, run
    typedef enum logic [1:0] {
        slp_st_capture = 2'b00,
        slp_st_wait = 2'b01,
        slp_st_ready = 2'b10
    } slp_state_e;

    // internal PHY status and events
    typedef struct packed {
        logic link;
        logic speed100;
        logic full_duplex;
        logic crs;
        logic wake_event;
    } slp_phy_s;

    // wake strap is the high bit, eeprom data out the low bit
    function automatic slp_width_e slp_decode_width(input logic wake,
                                                    input logic eeprom_data_out);
        return slp_width_e'({wake, eeprom_data_out});
    endfunction

endpackage

/* testbench.sv */
`timescale 1ns/1ns
`define CHK(a, b) \
    begin \
        n_tests++; \
        if ((a) !== (b)) \
        begin \
            bad_count++; \
            $display("CHECK FAILED %0t got %0h want %0h", $time, a, b); \
        end \
    end

module testbench;
    localparam int RC = 4;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    slp_pkg::slp_phy_s phy = '0;
    logic css = 1'b0;
    logic eed = 1'b0;
    logic ees = 1'b0;
    logic [6:0] gpi = 7'h00;
    logic [3:0] strap_hi = 4'h0;
    wire [3:0] op, pin_i, pin_o, pin_oe_n;
    logic ack, aux, aux_oe_n, from_aux, rdy, irq, mode, rmii;
    logic [6:0] gpo, gpoe_n;
    logic [2:0] led, led_oe_n;
    slp_pkg::slp_width_e width;
    logic [31:0] lfsr = 32'h0f05c772;
    int n_tests = 0;
    int bad_count = 0;

    // ****************************************
    // clock, design and board
    // ****************************************
    always #2 mclk = ~mclk;

    slp_misc_pins #(.READY_CYC(RC)) dut (
        .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .phy_i(phy),
        .operation_mode_straps(op), .clock_source_select(css),
        .eeprom_data_out_d(eed), .eeprom_select_d(ees),
        .wake_i(pin_i[0]), .wake_o(pin_o[0]), .wake_oe_n(pin_oe_n[0]),
        .eeprom_data_out_i(pin_i[1]), .eeprom_data_out_o(pin_o[1]),
        .eeprom_data_out_oe_n(pin_oe_n[1]),
        .eeprom_select_i(pin_i[2]), .eeprom_select_o(pin_o[2]),
        .eeprom_select_oe_n(pin_oe_n[2]),
        .link_status_i(pin_i[3]), .link_status_o(pin_o[3]),
        .link_status_oe_n(pin_oe_n[3]),
        .aux_clock_out_o(aux), .aux_clock_out_oe_n(aux_oe_n),
        .sys_clk_from_aux(from_aux), .general_pins_i(gpi),
        .general_pins_o(gpo), .general_pins_oe_n(gpoe_n), .led_o(led),
        .led_oe_n(led_oe_n), .mem_width(width), .led_mode(mode),
        .rev_mii(rmii), .ready_o(rdy), .irq_o(irq)
    );

    slp_board board (
        .strap_hi(strap_hi), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .pin_i(pin_i), .op_straps(op)
    );

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    // expected led enables, low means lit; p = link, speed, duplex, crs
    function automatic logic [2:0] exp_led(input logic [3:0] p,
                                           input logic m);
        int sp, dx, lk;
        sp = p[2];
        dx = m ? p[1] : !p[2];
        lk = m ? (p[3] && !p[0]) : p[0];
        return ~{lk[0], dx[0], sp[0]};
    endfunction

    // one classic bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do
        begin
            @(posedge mclk);
        end
        while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic do_reset(input logic [3:0] s);
        @(posedge mclk);
        rst_n <= 1'b0;
        strap_hi <= s;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        logic [31:0] r;
        int e;
        for (int s = 0; s < 16; s++)
        begin
            do_reset(s[3:0]);
            repeat (RC) @(posedge mclk);
            #1;
            `CHK(rdy, 1'b0)
            `CHK(gpoe_n, 7'h0e)
            `CHK(gpo, 7'h01)
            `CHK(pin_oe_n, 4'h0)
            @(posedge mclk);
            #1;
            `CHK(rdy, 1'b1)
            `CHK(width, slp_pkg::slp_width_e'({s[0], s[1]}))
            `CHK(mode, s[2])
            `CHK(rmii, s[3])
            wb(1'b0, 8'h08, 32'h0, 4'hf);
            `CHK(rdat[8:0], ({1'b1, 4'h3, s[3], s[2], s[0], s[1]}))
            for (int k = 0; k < 4; k++)
            begin
                @(posedge mclk);
                r = rnd();
                phy <= {r[3:0], 1'b0};
                eed <= r[4];
                ees <= r[5];
                repeat (2) @(posedge mclk);
                #1;
                `CHK(led_oe_n, exp_led(r[3:0], s[2]))
                `CHK(pin_o[3], r[3])
                `CHK(pin_o[2:1], ({r[5], r[4]}))
                `CHK(led, 3'h0)
            end
            $display("straps %0h done", s);
        end
        // general pin direction and data
        wb(1'b0, 8'h00, 32'h0, 4'hf);
        `CHK(rdat, 32'h71)
        wb(1'b1, 8'h00, 32'h0e, 4'hf);
        wb(1'b0, 8'h00, 32'h0, 4'hf);
        `CHK(rdat, 32'h7f)
        `CHK(gpoe_n, 7'h00)
        r = rnd();
        gpi <= r[14:8];
        wb(1'b1, 8'h04, {25'h0, r[6:0]}, 4'h1);
        `CHK(gpo, r[6:0])
        wb(1'b1, 8'h04, 32'h0, 4'he);
        `CHK(gpo, r[6:0])
        wb(1'b0, 8'h04, 32'h0, 4'hf);
        `CHK(rdat, ({25'h0, r[14:8]}))
        wb(1'b0, 8'h18, 32'h0, 4'hf);
        `CHK(rdat, 32'h0)
        $display("general pins done");
        // wake event, masked and unmasked
        wb(1'b0, 8'h10, 32'h0, 4'hf);
        for (int m = 1; m >= 0; m--)
        begin
            wb(1'b1, 8'h14, 32'(m), 4'hf);
            phy.wake_event <= 1'b1;
            @(posedge mclk);
            phy.wake_event <= 1'b0;
            repeat (2) @(posedge mclk);
            #1;
            `CHK(pin_o[0], 1'b1)
            `CHK(irq, m[0])
            wb(1'b0, 8'h10, 32'h0, 4'hf);
            `CHK(rdat[0], 1'b1)
            @(posedge mclk);
            #1;
            `CHK(pin_o[0], 1'b0)
            `CHK(irq, 1'b0)
        end
        $display("wake done");
        // aux clock rate over 1 us and clock source select
        e = 0;
        repeat (250)
        begin
            @(posedge mclk);
            if (aux && !r[0])
                e++;
            r[0] = aux;
        end
        `CHK(e inside {[19:21]}, 1'b1)
        css <= 1'b1;
        repeat (3) @(posedge mclk);
        `CHK(({from_aux, aux_oe_n}), 2'b11)
        css <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK(({from_aux, aux_oe_n}), 2'b00)
        $display("clocks done");
        final_report();
    end

    // watchdog against a hung bus cycle
    initial
    begin
        #40000;
        bad_count++;
        final_report();
    end
endmodule // testbench
